// ==== common/dyn_loop_defs.svh ====
// Register offsets, field positions, reset values and bounds of the threshold loop
`ifndef DYN_LOOP_DEFS_SVH
`define DYN_LOOP_DEFS_SVH

// Register offsets
`define DL_OFS_OP_BASE     8'h33
`define DL_OFS_CTL_ONE     8'h36
`define DL_OFS_CYC_LEN     8'h37
`define DL_OFS_LIMIT_BASE  8'h4e
`define DL_OFS_THR_BASE    8'h67
`define DL_OFS_STATUS      8'h6b

// Field positions in dynamic_loop_control_one
`define DL_BIT_R1_EN       5
`define DL_BIT_LOC_EN      6
`define DL_BIT_R2_EN       7
`define DL_BIT_R2_CODE_HI  0

// Field positions in dynamic_loop_cycle_lengths
`define DL_R1_CODE_LSB     0
`define DL_LOC_CODE_LSB    3
`define DL_R2_CODE_LSB     6

// Field positions in the status register
`define DL_STS_LOWER_LSB   0
`define DL_STS_RAISE_LSB   3

// Reset values
`define DL_RST_OP          8'ha4
`define DL_RST_LOW         8'h01
`define DL_RST_HIGH        8'h7f
`define DL_RST_CTL         8'h00
`define DL_RST_THR         8'h5a

// Loop cadence: shortest short pass in monitoring cycles
`define DL_SHORT_BASE      8
`define DL_CNT_W           11

// Threshold bounds in whole degrees
`define DL_FLOOR_TWOS      (-13'sd127)
`define DL_FLOOR_OFS64     (-13'sd64)
`define DL_CEIL_TWOS       13'sd127
`define DL_CEIL_OFS64      13'sd191
`define DL_OFS64_BIAS      13'sd64

// Largest rise still treated as drift, in quarter degrees
`define DL_DRIFT_Q         13'sd1

`endif

// ==== common/dyn_loop_pkg.sv ====
// Types and temperature format helpers for the threshold loop
package dyn_loop_pkg;
  `include "dyn_loop_defs.svh"

  typedef logic [7:0]        code_t;
  typedef logic signed [12:0] qdeg_t;

  // Channel order used everywhere
  typedef enum logic [1:0] {
    CH_REMOTE_ONE = 2'b00,
    CH_LOCAL      = 2'b01,
    CH_REMOTE_TWO = 2'b10,
    CH_NONE       = 2'b11
  } chan_e;

  // Whole state of the top module
  typedef struct packed {
    logic [2:0][7:0] op;
    logic [2:0][7:0] low;
    logic [2:0][7:0] high;
    logic [2:0][7:0] thr;
    logic [7:0]      ctl_one;
    logic [7:0]      cyc_len;
    logic [5:0]      sts;
    logic [2:0]      suspended;
    logic [7:0]      rdata;
  } loop_state_s;

  // Register code to signed whole degrees
  function automatic qdeg_t code_to_deg(input code_t code, input logic ofs64);
    qdeg_t d;
    if (ofs64) begin
      d = qdeg_t'({5'h00, code}) - `DL_OFS64_BIAS;
    end else begin
      d = qdeg_t'({{5{code[7]}}, code});
    end
    return d;
  endfunction

  // Register code plus fraction to quarter degrees
  function automatic qdeg_t code_to_q(input code_t code, input logic [1:0] frac,
                                      input logic ofs64);
    qdeg_t d;
    d = code_to_deg(code, ofs64);
    return (d <<< 2) + qdeg_t'({11'h000, frac});
  endfunction

  // Whole degrees back to register code
  function automatic code_t deg_to_code(input qdeg_t d, input logic ofs64);
    qdeg_t t;
    t = d + `DL_OFS64_BIAS;
    return ofs64 ? t[7:0] : d[7:0];
  endfunction
endpackage

// ==== common/pass_timer_if.sv ====
// Carrier between the register side and a channel's pass timer
interface pass_timer_if;
  logic       tick;
  logic       enable;
  logic [2:0] code;
  logic [9:0] temp;
  logic       short_pass;
  logic       long_pass;
  logic [9:0] prev_temp;
  logic       prev_ok;

  modport ctrl (
    output tick, enable, code, temp,
    input  short_pass, long_pass, prev_temp, prev_ok
  );
  modport timer (
    input  tick, enable, code, temp,
    output short_pass, long_pass, prev_temp, prev_ok
  );
endinterface

// ==== hw/pass_timer.sv ====
// Per-channel pass cadence counter and previous-sample holder
module pass_timer
  import dyn_loop_pkg::*;
#(
  parameter int CNT_W = `DL_CNT_W
) (
  // Clock and reset
  input wire logic     clk_sys,
  input wire logic     sys_rst,
  // Loop side
  pass_timer_if.timer  pt
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [9:0]       prev;
    logic             prev_ok;
  } timer_state_s;

  timer_state_s st_r;
  timer_state_s st_nxt;
  logic [CNT_W-1:0] short_last;
  logic [CNT_W-1:0] long_last;

  // The longest pass needs 2048 counts
  initial begin
    if (CNT_W < `DL_CNT_W) begin
      $error("pass_timer: CNT_W too small for code 111");
    end
  end

  // Pass ends: n-1 and 2n-1 of a 2n cycle frame
  always_comb begin
    short_last    = (CNT_W'(`DL_SHORT_BASE) << pt.code) - CNT_W'(1);
    // Doubling the base, not the code, keeps code 111 from wrapping to 000
    long_last     = (CNT_W'(2 * `DL_SHORT_BASE) << pt.code) - CNT_W'(1);
    pt.short_pass = pt.tick && pt.enable && ((st_r.cnt == short_last) ||
                                             (st_r.cnt == long_last));
    pt.long_pass  = pt.tick && pt.enable && (st_r.cnt == long_last);
    pt.prev_temp  = st_r.prev;
    pt.prev_ok    = st_r.prev_ok;
  end

  // Counter parks at zero while the channel is disabled
  always_comb begin
    st_nxt = st_r;
    if (!pt.enable) begin
      st_nxt.cnt = '0;
    end else if (pt.tick) begin
      st_nxt.cnt = (st_r.cnt == long_last) ? '0 : st_r.cnt + CNT_W'(1);
    end
    if (pt.tick) begin
      st_nxt.prev    = pt.temp;
      st_nxt.prev_ok = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule

// ==== hw/dynamic_fan_threshold_loop.sv ====
// Dynamic fan turn-on threshold loop with its register file
//
// The loop runs on the monitoring cycle tick. Each tick carries a fresh
// reading for all three channels. The decision below is taken in the tick
// cycle itself so the reading and the stored previous sample line up.
module dynamic_fan_threshold_loop
  import dyn_loop_pkg::*;
#(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input  wire logic            clk_sys,
  input  wire logic            sys_rst,
  // Register port
  input  wire logic [7:0]      reg_addr,
  input  wire logic [7:0]      reg_wdata,
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  output      logic [7:0]      reg_rdata,
  // Monitoring side, same clock domain
  input  wire logic            monitor_tick,
  input  wire logic            offset64_mode,
  input  wire logic [2:0][9:0] temp_reading,
  input  wire logic [2:0][7:0] hysteresis,
  // Results
  output      logic [2:0][7:0] fan_turn_on_threshold,
  output      logic [2:0]      fan_off_request
);

  // Register map and channel layout are fixed at three channels
  initial begin
    if (NUM_CH != 3) begin
      $error("dynamic_fan_threshold_loop: NUM_CH must be 3");
    end
  end

  loop_state_s st_r;
  loop_state_s st_nxt;
  logic [2:0]  zone_adjust_enable;
  logic [2:0][2:0] cycle_code;
  logic [2:0]  short_pass;
  logic [2:0]  long_pass;
  logic [2:0][9:0] prev_temp;
  logic [2:0]  prev_ok;

  // Which of three registers, spaced step apart, an address hits
  function automatic chan_e chan_at(input logic [7:0] addr, input logic [7:0] base,
                                    input logic [7:0] step);
    chan_e c;
    c = CH_NONE;
    if (addr == base) begin
      c = CH_REMOTE_ONE;
    end else if (addr == base + step) begin
      c = CH_LOCAL;
    end else if (addr == base + (step << 1)) begin
      c = CH_REMOTE_TWO;
    end
    return c;
  endfunction

  // Per-channel enables, in channel order
  assign zone_adjust_enable[CH_REMOTE_ONE] = st_r.ctl_one[`DL_BIT_R1_EN];
  assign zone_adjust_enable[CH_LOCAL]      = st_r.ctl_one[`DL_BIT_LOC_EN];
  assign zone_adjust_enable[CH_REMOTE_TWO] = st_r.ctl_one[`DL_BIT_R2_EN];

  // Cycle length codes; the split code keeps control one bit 0 as its MSB
  assign cycle_code[CH_REMOTE_ONE] = st_r.cyc_len[`DL_R1_CODE_LSB +: 3];
  assign cycle_code[CH_LOCAL]      = st_r.cyc_len[`DL_LOC_CODE_LSB +: 3];
  assign cycle_code[CH_REMOTE_TWO] = {st_r.ctl_one[`DL_BIT_R2_CODE_HI],
                                      st_r.cyc_len[`DL_R2_CODE_LSB +: 2]};

  // One pass timer per channel
  generate
    for (genvar g = 0; g < 3; g++) begin : g_timer
      pass_timer_if pt_link ();

      assign pt_link.tick   = monitor_tick;
      assign pt_link.enable = zone_adjust_enable[g];
      assign pt_link.code   = cycle_code[g];
      assign pt_link.temp   = temp_reading[g];
      assign short_pass[g]  = pt_link.short_pass;
      assign long_pass[g]   = pt_link.long_pass;
      assign prev_temp[g]   = pt_link.prev_temp;
      assign prev_ok[g]     = pt_link.prev_ok;

      pass_timer #(
        .CNT_W (`DL_CNT_W)
      ) u_timer (
        .clk_sys (clk_sys),
        .sys_rst (sys_rst),
        .pt      (pt_link.timer)
      );
    end
  endgenerate

  // Next state: register writes, read data and the threshold decision
  always_comb begin
    chan_e  wc;
    chan_e  rc;
    chan_e  lc;
    qdeg_t  tq;
    qdeg_t  pq;
    qdeg_t  rise;
    qdeg_t  thr_d;
    qdeg_t  op_d;
    qdeg_t  low_d;
    qdeg_t  high_d;
    qdeg_t  hyst_d;
    qdeg_t  delta;
    qdeg_t  cand;
    qdeg_t  floor_d;
    qdeg_t  ceil_d;
    logic   lowered;
    logic   raised;
    logic [2:0] thr_written;

    st_nxt      = st_r;
    thr_written = 3'b000;
    wc          = CH_NONE;
    rc          = CH_NONE;
    lc          = CH_NONE;
    tq          = '0;
    pq          = '0;
    rise        = '0;
    thr_d       = '0;
    op_d        = '0;
    low_d       = '0;
    high_d      = '0;
    hyst_d      = '0;
    delta       = '0;
    cand        = '0;
    lowered     = 1'b0;
    raised      = 1'b0;
    floor_d     = offset64_mode ? `DL_FLOOR_OFS64 : `DL_FLOOR_TWOS;
    ceil_d      = offset64_mode ? `DL_CEIL_OFS64 : `DL_CEIL_TWOS;

    // Register writes
    if (reg_wr) begin
      wc = chan_at(reg_addr, `DL_OFS_OP_BASE, 8'h01);
      if (wc != CH_NONE) begin
        st_nxt.op[wc] = reg_wdata;
      end
      wc = chan_at(reg_addr, `DL_OFS_LIMIT_BASE, 8'h02);
      if (wc != CH_NONE) begin
        st_nxt.low[wc] = reg_wdata;
      end
      lc = chan_at(reg_addr, `DL_OFS_LIMIT_BASE + 8'h01, 8'h02);
      if (lc != CH_NONE) begin
        st_nxt.high[lc] = reg_wdata;
      end
      wc = chan_at(reg_addr, `DL_OFS_THR_BASE, 8'h01);
      if (wc != CH_NONE) begin
        st_nxt.thr[wc]  = reg_wdata;
        thr_written[wc] = 1'b1;
      end
      if (reg_addr == `DL_OFS_CTL_ONE) begin
        st_nxt.ctl_one = reg_wdata;
      end
      if (reg_addr == `DL_OFS_CYC_LEN) begin
        st_nxt.cyc_len = reg_wdata;
      end
      // Write one to clear; a same-cycle event sets it again below
      if (reg_addr == `DL_OFS_STATUS) begin
        st_nxt.sts = st_r.sts & ~reg_wdata[5:0];
      end
    end

    // Threshold decision per channel, taken on the tick
    for (int c = 0; c < 3; c++) begin
      tq     = code_to_q(temp_reading[c][9:2], temp_reading[c][1:0], offset64_mode);
      pq     = code_to_q(prev_temp[c][9:2], prev_temp[c][1:0], offset64_mode);
      rise   = tq - pq;
      thr_d  = code_to_deg(st_r.thr[c], offset64_mode);
      op_d   = code_to_deg(st_r.op[c], offset64_mode);
      low_d  = code_to_deg(st_r.low[c], offset64_mode);
      high_d = code_to_deg(st_r.high[c], offset64_mode);
      hyst_d = qdeg_t'({5'h00, hysteresis[c]});
      delta  = '0;

      // Fan held off below threshold; level refreshed on every tick
      if (monitor_tick) begin
        st_nxt.suspended[c] = tq < (thr_d <<< 2);
      end

      // Suspended, disabled or no pass this tick: threshold holds
      if (zone_adjust_enable[c] && tq >= (thr_d <<< 2)) begin
        // Short pass: two degrees per degree of rise, quarter steps drift
        if (short_pass[c] && prev_ok[c] && tq > ((op_d - hyst_d) <<< 2) &&
            rise > `DL_DRIFT_Q) begin
          delta = delta - (rise >>> 1);
        end
        // Long pass: lower only once above the target itself
        if (long_pass[c] && tq > (op_d <<< 2)) begin
          delta = delta - 13'sd1;
        end
        // Long pass raise: cool zone, threshold has headroom
        if (long_pass[c] && tq < (low_d <<< 2) && thr_d < high_d &&
            thr_d < op_d && tq > (thr_d <<< 2)) begin
          delta = delta + 13'sd1;
        end
      end

      // Saturate instead of wrapping in either direction
      cand = thr_d + delta;
      if (cand < floor_d) begin
        cand = floor_d;
      end
      if (delta > 13'sd0 && cand > high_d) begin
        cand = high_d;
      end
      if (cand > ceil_d) begin
        cand = ceil_d;
      end
      lowered = cand < thr_d;
      raised  = cand > thr_d;

      // Hardware adjustment loses to a same-cycle software write
      if ((lowered || raised) && !thr_written[c]) begin
        st_nxt.thr[c] = deg_to_code(cand, offset64_mode);
      end
      // Event flags: set wins over a same-cycle clear
      if (lowered) begin
        st_nxt.sts[`DL_STS_LOWER_LSB + c] = 1'b1;
      end
      if (raised) begin
        st_nxt.sts[`DL_STS_RAISE_LSB + c] = 1'b1;
      end
    end

    // Read data stands for one cycle only; unmapped reads give zero
    st_nxt.rdata = 8'h00;
    if (reg_rd) begin
      rc = chan_at(reg_addr, `DL_OFS_OP_BASE, 8'h01);
      if (rc != CH_NONE) begin
        st_nxt.rdata = st_r.op[rc];
      end
      rc = chan_at(reg_addr, `DL_OFS_LIMIT_BASE, 8'h02);
      if (rc != CH_NONE) begin
        st_nxt.rdata = st_r.low[rc];
      end
      rc = chan_at(reg_addr, `DL_OFS_LIMIT_BASE + 8'h01, 8'h02);
      if (rc != CH_NONE) begin
        st_nxt.rdata = st_r.high[rc];
      end
      rc = chan_at(reg_addr, `DL_OFS_THR_BASE, 8'h01);
      if (rc != CH_NONE) begin
        st_nxt.rdata = st_r.thr[rc];
      end
      case (reg_addr)
        `DL_OFS_CTL_ONE: begin
          st_nxt.rdata = st_r.ctl_one;
        end
        `DL_OFS_CYC_LEN: begin
          st_nxt.rdata = st_r.cyc_len;
        end
        `DL_OFS_STATUS: begin
          st_nxt.rdata = {2'b00, st_r.sts};
        end
        default: begin
          st_nxt.rdata = st_nxt.rdata;
        end
      endcase
    end
  end

  // Single state register
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      st_r.op        <= {3{`DL_RST_OP}};
      st_r.low       <= {3{`DL_RST_LOW}};
      st_r.high      <= {3{`DL_RST_HIGH}};
      st_r.thr       <= {3{`DL_RST_THR}};
      st_r.ctl_one   <= `DL_RST_CTL;
      st_r.cyc_len   <= `DL_RST_CTL;
      st_r.sts       <= 6'h00;
      st_r.suspended <= 3'h0;
      st_r.rdata     <= 8'h00;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs straight from flops
  assign reg_rdata             = st_r.rdata;
  assign fan_turn_on_threshold = st_r.thr;
  assign fan_off_request       = st_r.suspended;

endmodule

// ==== dv/dynamic_fan_threshold_loop_asserts.sv ====
// Port-level assertions for the dynamic fan threshold loop
module dynamic_fan_threshold_loop_asserts #(
  parameter int NUM_CH = 3
) (
  // Clock and reset
  input wire logic            clk_sys,
  input wire logic            sys_rst,
  // Register port
  input wire logic [7:0]      reg_addr,
  input wire logic [7:0]      reg_wdata,
  input wire logic            reg_wr,
  input wire logic            reg_rd,
  input wire logic [7:0]      reg_rdata,
  // Monitoring side
  input wire logic            monitor_tick,
  input wire logic            offset64_mode,
  input wire logic [2:0][9:0] temp_reading,
  input wire logic [2:0][7:0] hysteresis,
  // Results
  input wire logic [2:0][7:0] fan_turn_on_threshold,
  input wire logic [2:0]      fan_off_request
);
  logic [7:0]      ctl_r;
  logic [7:0]      cyc_r;
  logic [2:0][7:0] high_r;

  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  // Shadow of the registers the properties lean on
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      ctl_r  <= 8'h00;
      cyc_r  <= 8'h00;
      high_r <= {3{8'h7f}};
    end else if (reg_wr) begin
      if (reg_addr == 8'h36) ctl_r <= reg_wdata;
      if (reg_addr == 8'h37) cyc_r <= reg_wdata;
      for (int i = 0; i < 3; i++) begin
        if (reg_addr == 8'(8'h4f + 2 * i)) high_r[i] <= reg_wdata;
      end
    end
  end

  chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read answer");
  chk_code_readback: assert property (
    $past(reg_rd) && $past(reg_addr[7:1]) == 7'h1b
    |-> reg_rdata == ($past(reg_addr[0]) ? $past(cyc_r) : $past(ctl_r)))
    else $error("control register readback wrong");
  chk_thr_quiet: assert property (
    !monitor_tick && !reg_wr |=> $stable(fan_turn_on_threshold))
    else $error("threshold moved without tick or write");
  chk_fan_off_hold: assert property (!monitor_tick |=> $stable(fan_off_request))
    else $error("fan off request moved without tick");

  // Per channel relations
  for (genvar i = 0; i < 3; i++) begin : g_ch
    chk_hold_disabled: assert property (
      monitor_tick && !reg_wr && !ctl_r[5+i] |=> $stable(fan_turn_on_threshold[i]))
      else $error("threshold moved on a disabled channel");
    chk_suspend_below: assert property (
      monitor_tick && !reg_wr && !offset64_mode &&
      $signed(temp_reading[i]) < $signed({fan_turn_on_threshold[i], 2'b00})
      |=> $stable(fan_turn_on_threshold[i]))
      else $error("threshold moved while temperature below it");
    chk_floor_kept: assert property (
      monitor_tick && !reg_wr && !offset64_mode
      |=> $stable(fan_turn_on_threshold[i]) || $signed(fan_turn_on_threshold[i]) >= -127)
      else $error("threshold lowered under floor");
    chk_raise_step: assert property (
      monitor_tick && !reg_wr && !offset64_mode
      |=> $signed(fan_turn_on_threshold[i]) <= $signed($past(fan_turn_on_threshold[i])) ||
          ($signed(fan_turn_on_threshold[i]) == $signed($past(fan_turn_on_threshold[i])) + 1
           && $signed(fan_turn_on_threshold[i]) <= $signed(high_r[i])))
      else $error("threshold raise too large or above high limit");
  end

  // Main scenarios reached
  cover property (monitor_tick ##1 fan_turn_on_threshold[0] != $past(fan_turn_on_threshold[0]));
  cover property (monitor_tick && fan_off_request[0]);
  cover property (reg_rd ##1 reg_rdata != 8'h00);
endmodule

bind dynamic_fan_threshold_loop dynamic_fan_threshold_loop_asserts #(.NUM_CH(NUM_CH)) u_chk (
  .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
  .offset64_mode(offset64_mode), .temp_reading(temp_reading), .hysteresis(hysteresis),
  .fan_turn_on_threshold(fan_turn_on_threshold), .fan_off_request(fan_off_request)
);

// ==== dv/dynamic_fan_threshold_loop_tb_top.sv ====
// Self-checking bench with a behavioural model of the threshold loop
module dynamic_fan_threshold_loop_tb_top;
  timeunit 1ns;
  timeprecision 1ps;

  logic            clk_sys = 1'b0;
  logic            sys_rst = 1'b1;
  logic [7:0]      reg_addr = 8'h00;
  logic [7:0]      reg_wdata = 8'h00;
  logic            reg_wr = 1'b0;
  logic            reg_rd = 1'b0;
  logic [7:0]      reg_rdata;
  logic            monitor_tick = 1'b0;
  logic            offset64_mode = 1'b0;
  logic [2:0][9:0] temp_reading = '0;
  logic [2:0][7:0] hysteresis = '0;
  logic [2:0][7:0] fan_turn_on_threshold;
  logic [2:0]      fan_off_request;
  // Model: register mirror, pass counters, previous samples
  logic [7:0]      rg [256];
  logic [2:0][9:0] prv = '0;
  int              cnt [3] = '{0, 0, 0};
  int              w [3] = '{160, 200, 240};
  int              error_cnt = 0;
  int              total_checks = 0;
  int              cyc = 0;
  int              seed = 32'hb902e046;

  dynamic_fan_threshold_loop u_dynamic_fan_threshold_loop (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .monitor_tick(monitor_tick),
    .offset64_mode(offset64_mode), .temp_reading(temp_reading), .hysteresis(hysteresis),
    .fan_turn_on_threshold(fan_turn_on_threshold), .fan_off_request(fan_off_request)
  );

  always #5 clk_sys = ~clk_sys;

  // Hang guard, far above the few thousand cycles the run needs
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk8(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic chk1(input string nm, input logic exp, input logic got);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %s expected %b seen %b", nm, exp, got);
    end
  endtask

  function automatic bit mapped(input logic [7:0] a);
    return (a >= 8'h33 && a <= 8'h37) || (a >= 8'h4e && a <= 8'h53) ||
           (a >= 8'h67 && a <= 8'h69) || a == 8'h6b;
  endfunction

  // Code to whole degrees, and raw reading to quarter degrees
  function automatic int dg(input logic [7:0] c);
    return offset64_mode ? int'(c) - 64 : int'($signed(c));
  endfunction
  function automatic int qt(input logic [9:0] t);
    return dg(t[9:2]) * 4 + int'(t[1:0]);
  endfunction

  // Status is write-one-to-clear; unmapped writes leave the mirror alone
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    if (a == 8'h6b) rg[a] = rg[a] & ~d;
    else if (mapped(a)) rg[a] = d;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 chk8("reg_rdata", mapped(a) ? rg[a] : 8'h00, reg_rdata);
    @(posedge clk_sys);
    #1 chk8("reg_rdata idle", 8'h00, reg_rdata);
  endtask

  // One monitoring cycle: drive the reading, step the model, compare
  task automatic tick(input logic [2:0][9:0] t);
    int k, n, q, th, nt, d, fl;
    bit sp, lp, en;
    bit fo_ok [3];
    logic fo [3];
    @(posedge clk_sys);
    temp_reading <= t;
    monitor_tick <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      k = i == 0 ? int'(rg[8'h37][2:0]) : i == 1 ? int'(rg[8'h37][5:3]) :
          int'({rg[8'h36][0], rg[8'h37][7:6]});
      n = 8 << k;
      en = rg[8'h36][5+i];
      sp = en && (cnt[i] == n - 1 || cnt[i] == 2 * n - 1);
      lp = en && cnt[i] == 2 * n - 1;
      cnt[i] = en && !lp ? cnt[i] + 1 : 0;
      q = qt(t[i]);
      th = dg(rg[8'h67+i]);
      d = 0;
      if (q >= th * 4) begin
        if (sp && q > (dg(rg[8'h33+i]) - int'(hysteresis[i])) * 4 && q - qt(prv[i]) > 1)
          d = (qt(prv[i]) - q) / 2;
        if (lp && q > dg(rg[8'h33+i]) * 4) d = d - 1;
        else if (lp && q < dg(rg[8'h4e+2*i]) * 4 && th < dg(rg[8'h4f+2*i]) &&
                 th < dg(rg[8'h33+i]) && q > th * 4) d = d + 1;
      end
      fl = offset64_mode ? -64 : -127;
      nt = th + d < fl ? fl : th + d;
      if (nt < th) rg[8'h6b][i] = 1'b1;
      if (nt > th) rg[8'h6b][3+i] = 1'b1;
      fo[i] = q < th * 4;
      fo_ok[i] = fo[i] == (q < nt * 4);
      rg[8'h67+i] = 8'(offset64_mode ? nt + 64 : nt);
      prv[i] = t[i];
    end
    @(posedge clk_sys);
    monitor_tick <= 1'b0;
    #1;
    for (int i = 0; i < 3; i++) begin
      chk8("threshold", rg[8'h67+i], fan_turn_on_threshold[i]);
      if (fo_ok[i]) chk1("fan_off_request", fo[i], fan_off_request[i]);
    end
  endtask

  // Random walk of all three readings, clamped to 16..72 degrees
  task automatic walk(input int num);
    logic [2:0][9:0] t;
    repeat (num) begin
      for (int i = 0; i < 3; i++) begin
        w[i] = w[i] + $random(seed) % 7;
        w[i] = w[i] < 64 ? 64 : w[i] > 288 ? 288 : w[i];
        t[i] = 10'(w[i]);
      end
      tick(t);
    end
  endtask

  initial begin
    for (int a = 0; a < 256; a++) rg[a] = 8'h00;
    for (int i = 0; i < 3; i++) begin
      rg[8'h33+i] = 8'ha4;
      rg[8'h4e+2*i] = 8'h01;
      rg[8'h4f+2*i] = 8'h7f;
      rg[8'h67+i] = 8'h5a;
    end
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int a = 8'h30; a < 8'h70; a++) rd(8'(a));
    wr(8'h40, 8'h5c);
    rd(8'h40);
    // Three codes at once, remote two using the split high bit
    for (int i = 0; i < 3; i++) begin
      wr(8'(8'h33 + i), 8'h30);
      wr(8'(8'h4e + 2 * i), 8'h20);
      wr(8'(8'h4f + 2 * i), 8'h40);
      wr(8'(8'h67 + i), 8'h28);
      hysteresis[i] <= 8'($random(seed)) & 8'h07;
    end
    wr(8'h37, 8'h08);
    wr(8'h36, 8'he1);
    rd(8'h36);
    rd(8'h37);
    walk(700);
    rd(8'h6b);
    wr(8'h6b, 8'hff);
    rd(8'h6b);
    wr(8'h36, 8'ha1);
    walk(100);
    // Fast rise above target drives the threshold onto its floor, both formats
    for (int m = 0; m < 2; m++) begin
      wr(8'h36, 8'h00);
      tick(temp_reading);
      offset64_mode <= 1'(m);
      wr(8'h37, 8'h00);
      for (int i = 0; i < 3; i++) begin
        wr(8'(8'h33 + i), m ? 8'h10 : 8'h90);
        wr(8'(8'h67 + i), m ? 8'h04 : 8'h84);
      end
      wr(8'h36, 8'he0);
      for (int j = 0; j < 40; j++)
        tick({3{{(m ? 8'h18 : 8'h98) + 8'(2 * j), 2'($random(seed))}}});
    end
    print_verdict();
  end
endmodule
